// file: core/swl_link.sv
// device end of the single-wire link with the offset result and mode registers.
// assumes the data line input is synchronous to mclk and the pad is open drain.
// Functional notes
// - offset result readable at address 73h
// - offset is signed byte, msb discharge
// - offset counter starts at zero, counts both ways
// - device read bit cycles 190 to 250 us
// - device start portion low 32 us+
// - reply starts 190 to 320 us after command
// - calibration done loads offset, clears request bit
module swl_link
    import swl_pkg::*;
#(
    parameter int RD_CYC_CLKS = RD_CYC_CYC,
    parameter int RD_STR_CLKS = RD_STR_CYC,
    parameter int RD_DAT_CLKS = RD_DAT_CYC,
    parameter int RESP_CLKS = RESP_CYC,
    parameter int SAMPLE_CLKS = SAMPLE_CYC,
    parameter int BREAK_CLKS = BREAK_DET_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic single_wire_data_line_in,
    output logic single_wire_data_line_out,
    output logic single_wire_data_line_oe,
    input wire swl_cal_s cal_in,
    output logic cal_active,
    output logic [7:0] sense_offset_result,
    output logic offset_direction_bit
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // defaults meet the line timing; scaled sets only need their order to hold
    if (RD_STR_CLKS < 1 || RD_DAT_CLKS <= RD_STR_CLKS || RD_CYC_CLKS <= RD_DAT_CLKS ||
        RESP_CLKS < 1 || SAMPLE_CLKS < 1 || SAMPLE_CLKS >= BREAK_CLKS ||
        BREAK_CLKS >= (1 << TMR_W) || RD_CYC_CLKS >= (1 << TMR_W) ||
        RESP_CLKS >= (1 << TMR_W)) begin : g_bad_timing
        $error("swl_link: timing parameters cannot be served");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    swl_state_e st_ff;
    logic [TMR_W-1:0] tmr_ff;
    logic [4:0] bitcnt_ff;
    logic [15:0] rx_sh_ff;
    logic [7:0] tx_sh_ff;
    logic [2:0] txcnt_ff;
    logic dq_prev_ff;
    logic dq_oe_ff;
    logic [7:0] offset_ff;
    logic [7:0] cnt_ff;
    logic cal_ff;
    logic ovr_ff;

    logic dq_fall;
    logic dq_rise;
    logic [7:0] cmd;
    logic [7:0] rd_data;
    logic wr_mode;
    logic cal_hit;
    logic nxt_oe;
    logic frame_end;

    assign dq_fall = dq_prev_ff && !single_wire_data_line_in;
    assign dq_rise = !dq_prev_ff && single_wire_data_line_in;
    assign cmd = rx_sh_ff[15:8];
    // a one bit rises before its sample point, so its end is taken just after sampling
    assign frame_end = single_wire_data_line_in
                       && (dq_rise || tmr_ff == TMR_W'(SAMPLE_CLKS));
    assign wr_mode = st_ff == ST_RX && frame_end && bitcnt_ff == 5'(2 * FRAME_BITS)
                     && rx_sh_ff[CMD_WR_BIT] && rx_sh_ff[6:0] == ADDR_MODE;
    // calibration runs only with the line low, unless the override is set
    assign cal_active = cal_ff && cal_in.quiet && (ovr_ff || !single_wire_data_line_in);
    assign cal_hit = cal_active && cal_in.done;

    always_comb begin
        rd_data = 8'h00;
        if (cmd[6:0] == ADDR_OFFSET) begin
            rd_data = offset_ff;
        end else if (cmd[6:0] == ADDR_MODE) begin
            rd_data[MODE_OVR_BIT] = ovr_ff;
            rd_data[MODE_CAL_BIT] = cal_ff;
        end
    end

    // ------------------------------------------------------------
    // line framing
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dq_prev_ff <= 1'b1;
        end else if (ce) begin
            dq_prev_ff <= single_wire_data_line_in;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= ST_IDLE;
            tmr_ff <= '0;
            bitcnt_ff <= '0;
            rx_sh_ff <= '0;
            tx_sh_ff <= '0;
            txcnt_ff <= '0;
        end else if (ce) begin
            case (st_ff)
                ST_IDLE: begin
                    bitcnt_ff <= '0;
                    if (dq_fall) begin
                        st_ff <= ST_RX;
                        tmr_ff <= '0;
                    end
                end
                ST_RX: begin
                    if (tmr_ff != '1) begin
                        tmr_ff <= tmr_ff + 1'b1;
                    end
                    if (dq_fall) begin
                        tmr_ff <= '0;
                    end else if (!single_wire_data_line_in
                                 && tmr_ff == TMR_W'(BREAK_CLKS - 1)) begin
                        // a long low restarts framing whatever was under way
                        st_ff <= ST_BRK;
                    end else if (tmr_ff == TMR_W'(SAMPLE_CLKS - 1)) begin
                        rx_sh_ff <= {single_wire_data_line_in, rx_sh_ff[15:1]};
                        bitcnt_ff <= bitcnt_ff + 1'b1;
                    end else if (frame_end && bitcnt_ff == 5'(FRAME_BITS)
                                 && !cmd[CMD_WR_BIT]) begin
                        st_ff <= ST_RESP;
                        tmr_ff <= '0;
                    end else if (frame_end && bitcnt_ff == 5'(2 * FRAME_BITS)) begin
                        st_ff <= ST_IDLE;
                    end
                end
                ST_RESP: begin
                    tmr_ff <= tmr_ff + 1'b1;
                    if (tmr_ff == TMR_W'(RESP_CLKS - 1)) begin
                        st_ff <= ST_TX;
                        tmr_ff <= '0;
                        tx_sh_ff <= rd_data;
                        txcnt_ff <= '0;
                    end
                end
                ST_TX: begin
                    tmr_ff <= tmr_ff + 1'b1;
                    if (tmr_ff == TMR_W'(RD_CYC_CLKS - 1)) begin
                        tmr_ff <= '0;
                        tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                        txcnt_ff <= txcnt_ff + 1'b1;
                        if (txcnt_ff == 3'(FRAME_BITS - 1)) begin
                            st_ff <= ST_IDLE;
                        end
                    end
                end
                ST_BRK: begin
                    bitcnt_ff <= '0;
                    if (single_wire_data_line_in) begin
                        st_ff <= ST_IDLE;
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // line driver
    // ------------------------------------------------------------
    // start low, then data
    always_comb begin
        nxt_oe = 1'b0;
        if (st_ff == ST_TX) begin
            nxt_oe = tmr_ff < TMR_W'(RD_STR_CLKS)
                     || (tmr_ff < TMR_W'(RD_DAT_CLKS) && !tx_sh_ff[0]);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dq_oe_ff <= 1'b0;
        end else if (ce) begin
            dq_oe_ff <= nxt_oe;
        end
    end

    // open drain: only ever pulls low
    assign single_wire_data_line_out = 1'b0;
    assign single_wire_data_line_oe = dq_oe_ff;

    // ------------------------------------------------------------
    // calibration and registers
    // ------------------------------------------------------------
    // counter centred on zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_ff <= OFFSET_CENTER;
        end else if (ce) begin
            if (!cal_ff) begin
                cnt_ff <= OFFSET_CENTER;
            end else if (cal_active && cal_in.step) begin
                // saturate rather than wrap, so the sign stays honest
                if (cal_in.up && cnt_ff != OFFSET_POS_MAX) begin
                    cnt_ff <= cnt_ff + 1'b1;
                end else if (!cal_in.up && cnt_ff != OFFSET_NEG_MAX) begin
                    cnt_ff <= cnt_ff - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            offset_ff <= OFFSET_RST;
        end else if (ce && cal_hit) begin
            offset_ff <= cnt_ff;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cal_ff <= 1'b0;
            ovr_ff <= 1'b0;
        end else if (ce) begin
            if (wr_mode) begin
                cal_ff <= rx_sh_ff[8 + MODE_CAL_BIT];
                ovr_ff <= rx_sh_ff[8 + MODE_OVR_BIT];
            end else if (cal_hit) begin
                cal_ff <= 1'b0;
                ovr_ff <= 1'b0;
            end
        end
    end

    assign sense_offset_result = offset_ff;
    assign offset_direction_bit = offset_ff[7];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_OFS_CAUSE: assert property (@(posedge mclk iff ce) disable iff (rst)
        $changed(offset_ff) |-> $past(cal_hit))
        else $error("offset changed without calibration");

    AST_CAL_DONE: assert property (@(posedge mclk iff ce) disable iff (rst)
        cal_hit && !wr_mode |=> !cal_ff && !ovr_ff && offset_ff == $past(cnt_ff))
        else $error("calibration completion not applied");

    AST_CNT_ZERO: assert property (@(posedge mclk iff ce) disable iff (rst)
        !cal_ff |=> cnt_ff == OFFSET_CENTER)
        else $error("offset counter not centred");

    AST_CNT_STEP: assert property (@(posedge mclk iff ce) disable iff (rst)
        cal_active && cal_in.step && !cal_in.up && cnt_ff != OFFSET_NEG_MAX
        |=> cnt_ff == $past(cnt_ff) - 8'h01)
        else $error("offset counter failed to count down");

    AST_STR_LOW: assert property (@(posedge mclk iff ce) disable iff (rst)
        st_ff == ST_TX && tmr_ff != '0 && tmr_ff <= TMR_W'(RD_STR_CLKS) |-> dq_oe_ff)
        else $error("start portion not held low");

    AST_TX_LEN: assert property (@(posedge mclk iff ce) disable iff (rst)
        st_ff == ST_TX |-> tmr_ff < TMR_W'(RD_CYC_CLKS))
        else $error("read bit cycle too long");

    AST_RESP: assert property (@(posedge mclk iff ce) disable iff (rst)
        $rose(st_ff == ST_TX) |-> $past(st_ff) == ST_RESP
        && $past(tmr_ff) == TMR_W'(RESP_CLKS - 1))
        else $error("reply not at response delay");

    AST_OFS_READ: assert property (@(posedge mclk iff ce) disable iff (rst)
        $rose(st_ff == ST_TX) && cmd[6:0] == ADDR_OFFSET |-> tx_sh_ff == $past(offset_ff))
        else $error("read of offset returned wrong value");
endmodule // swl_link

// file: core/swl_pkg.sv
// package for the single-wire offset link: map, bit fields, carriers, timing.
// assumes one 250 MHz clock; the line times below are in microseconds, the clock period in ns.
package swl_pkg;
    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_OFFSET = 7'h73;
    localparam logic [6:0] ADDR_MODE = 7'h75;
    localparam int MODE_OVR_BIT = 7;
    localparam int MODE_CAL_BIT = 6;
    localparam int CMD_WR_BIT = 7;
    localparam int FRAME_BITS = 8;
    localparam logic [7:0] OFFSET_RST = 8'h00;
    localparam logic [7:0] OFFSET_CENTER = 8'h00;
    localparam logic [7:0] OFFSET_POS_MAX = 8'h7f;
    localparam logic [7:0] OFFSET_NEG_MAX = 8'h80;
    localparam int TMR_W = 17;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int RD_CYC_MIN_US = 190;
    localparam int RD_CYC_MAX_US = 250;
    localparam int RD_CYC_US = 205;
    localparam int RD_STR_MIN_US = 32;
    localparam int RD_STR_US = 40;
    localparam int RD_DAT_US = 110;
    localparam int RESP_MIN_US = 190;
    localparam int RESP_MAX_US = 320;
    localparam int RESP_US = 200;
    localparam int SAMPLE_US = 100;
    localparam int BREAK_DET_US = 170;
    // least times round up, longest times round down
    localparam int RD_CYC_MIN_CYC = (RD_CYC_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_CYC_MAX_CYC = RD_CYC_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int RD_CYC_CYC = RD_CYC_US * 1000 / CLK_PERIOD_NS;
    localparam int RD_STR_MIN_CYC = (RD_STR_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_STR_CYC = RD_STR_US * 1000 / CLK_PERIOD_NS;
    localparam int RD_DAT_CYC = RD_DAT_US * 1000 / CLK_PERIOD_NS;
    localparam int RESP_MIN_CYC = (RESP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESP_MAX_CYC = RESP_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int RESP_CYC = RESP_US * 1000 / CLK_PERIOD_NS;
    localparam int SAMPLE_CYC = SAMPLE_US * 1000 / CLK_PERIOD_NS;
    localparam int BREAK_DET_CYC = BREAK_DET_US * 1000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX = 5'b00010,
        ST_RESP = 5'b00100,
        ST_TX = 5'b01000,
        ST_BRK = 5'b10000
    } swl_state_e;

    typedef struct packed {
        logic quiet;
        logic step;
        logic up;
        logic done;
    } swl_cal_s;
endpackage

// file: tb/swl_host_model.sv
// host model for the single-wire link: sends command and data bits, times the replies.
// assumes a pulled-up line resolved in the bench; all counts are 4 ns cycles over DIV.
module swl_host_model
    import swl_pkg::*;
#(
    parameter int DIV = 1
) (
    input wire logic mclk,
    input wire logic line,
    output logic host_low,
    output logic rd_valid,
    output logic [8:0] rd_word,
    output logic hang
);
    timeunit 1ns;
    timeprecision 1ps;
    // line times shrink by DIV to keep a regression short; limits round inwards
    localparam int BIT_CLKS = 50000 / DIV;
    localparam int ONE_CLKS = 5000 / DIV;
    localparam int ZERO_CLKS = 37500 / DIV;
    localparam int GAP_CLKS = 12500 / DIV;
    localparam int ONE_MAX_CLKS = 18750 / DIV;
    localparam int RESP_LO = (RESP_MIN_CYC + DIV - 1) / DIV;
    localparam int RESP_HI = RESP_MAX_CYC / DIV;
    localparam int CYC_LO = (RD_CYC_MIN_CYC + DIV - 1) / DIV;
    localparam int CYC_HI = RD_CYC_MAX_CYC / DIV;
    localparam int STR_LO = (RD_STR_MIN_CYC + DIV - 1) / DIV;
    longint cnt = 0;
    longint last_rise = 0;

    initial begin
        host_low = 1'b0;
        rd_valid = 1'b0;
        rd_word = '0;
        hang = 1'b0;
    end

    always @(posedge mclk) begin
        cnt <= cnt + 1;
    end

    // ------------------------------------------------------------
    // bit level helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // every wait is bounded; running out flags a hang to the bench
    task automatic wait_line(input logic v, input int lim);
        int n;
        n = 0;
        while (line !== v && n < lim) begin
            tick(1);
            n++;
        end
        if (n >= lim) begin
            hang = 1'b1;
        end
    endtask

    task automatic send_bit(input logic b);
        host_low = 1'b1;
        tick(b ? ONE_CLKS : ZERO_CLKS);
        host_low = 1'b0;
        last_rise = cnt;
        tick(b ? BIT_CLKS - ONE_CLKS : BIT_CLKS - ZERO_CLKS);
    endtask

    // ------------------------------------------------------------
    // transfers
    // ------------------------------------------------------------
    task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
        int i;
        for (i = 0; i < 16; i++) begin
            send_bit(i < 7 ? addr[i] : (i == 7 ? 1'b1 : data[i-8]));
        end
        tick(GAP_CLKS);
    endtask

    task automatic hold_low(input int n);
        host_low = 1'b1;
        tick(n);
        host_low = 1'b0;
        tick(GAP_CLKS);
    endtask

    task automatic read_byte(input logic [6:0] addr);
        logic [7:0] d;
        logic ok;
        longint tf;
        longint tp;
        int i;
        ok = 1'b1;
        tp = 0;
        tf = 0;
        for (i = 0; i < 8; i++) begin
            send_bit(i == 7 ? 1'b0 : addr[i]);
        end
        for (i = 0; i < 8; i++) begin
            wait_line(1'b0, RESP_HI + CYC_HI);
            tf = cnt;
            if (i == 0) begin
                ok &= (tf - last_rise >= RESP_LO) && (tf - last_rise <= RESP_HI);
            end
            if (i > 0) begin
                ok &= (tf - tp >= CYC_LO) && (tf - tp <= CYC_HI);
            end
            wait_line(1'b1, CYC_HI);
            ok &= (cnt - tf >= STR_LO);
            // short low reads as one; sampled well between the two low lengths
            d[i] = (cnt - tf < ONE_MAX_CLKS);
            tp = tf;
        end
        tick(CYC_HI - int'(cnt - tf) + GAP_CLKS);
        rd_word = {ok, d};
        rd_valid = 1'b1;
        tick(1);
        rd_valid = 1'b0;
    endtask
endmodule // swl_host_model

// file: tb/tb_single_wire_offset_link.sv
// self-checking bench for the single-wire offset link device end.
// assumes the host model above; both ends run the line timing divided by DIV.
module tb_single_wire_offset_link
    import swl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // 125 keeps every scaled count whole and the run well short
    localparam int DIV = 125;
    logic mclk;
    logic rst;
    logic ce;
    logic line;
    logic dut_oe;
    logic dut_out;
    logic host_low;
    logic rd_valid;
    logic hang;
    logic cal_active;
    logic dir_bit;
    logic [8:0] rd_word;
    logic [7:0] offset;
    logic [7:0] r;
    swl_cal_s cal_in;
    logic [8:0] exp_q[$];
    int failures = 0;
    int n_checks = 0;
    int n;

    // open drain line with pull-up
    assign line = host_low ? 1'b0 : (dut_oe ? dut_out : 1'b1);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    swl_link #(
        .RD_CYC_CLKS(RD_CYC_CYC / DIV),
        .RD_STR_CLKS(RD_STR_CYC / DIV),
        .RD_DAT_CLKS(RD_DAT_CYC / DIV),
        .RESP_CLKS(RESP_CYC / DIV),
        .SAMPLE_CLKS(SAMPLE_CYC / DIV),
        .BREAK_CLKS(BREAK_DET_CYC / DIV)
    ) u_dut (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .single_wire_data_line_in(line),
        .single_wire_data_line_out(dut_out),
        .single_wire_data_line_oe(dut_oe),
        .cal_in(cal_in),
        .cal_active(cal_active),
        .sense_offset_result(offset),
        .offset_direction_bit(dir_bit)
    );

    swl_host_model #(
        .DIV(DIV)
    ) u_host (
        .mclk(mclk),
        .line(line),
        .host_low(host_low),
        .rd_valid(rd_valid),
        .rd_word(rd_word),
        .hang(hang)
    );

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] expv);
        n_checks++;
        if (seen !== expv) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task automatic results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        if (rd_valid === 1'b1) begin
            check(rd_word, exp_q.size() > 0 ? exp_q.pop_front() : 9'h000);
        end
    end

    always @(posedge hang) begin
        failures++;
        results();
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    task automatic step_clk();
        @(posedge mclk);
        #1;
    endtask

    // one step or done pulse, then a quiet cycle
    task automatic cal_pulse(input logic up, input logic done);
        cal_in = '{quiet: 1'b1, step: ~done, up: up, done: done};
        step_clk();
        cal_in = '{quiet: 1'b1, step: 1'b0, up: up, done: 1'b0};
        step_clk();
    endtask

    initial begin
        void'($urandom(74));
        rst = 1'b1;
        ce = 1'b1;
        cal_in = '0;
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        step_clk();
        exp_q.push_back({1'b1, OFFSET_RST});
        u_host.read_byte(ADDR_OFFSET);
        // override lets calibration run with the line high; drive past the negative limit
        u_host.write_reg(ADDR_MODE, 8'hc0);
        cal_in = '{quiet: 1'b1, step: 1'b0, up: 1'b0, done: 1'b0};
        step_clk();
        check({8'h00, cal_active}, 9'h001);
        repeat (130) cal_pulse(1'b0, 1'b0);
        cal_pulse(1'b0, 1'b1);
        check({dir_bit, offset}, {1'b1, OFFSET_NEG_MAX});
        exp_q.push_back(9'h100);
        u_host.read_byte(ADDR_MODE);
        // second run needs the line low, which the host holds as a break
        n = 1 + $urandom % 20;
        u_host.write_reg(ADDR_MODE, 8'h40);
        fork
            u_host.hold_low(50000 / DIV);
            begin
                repeat (10) step_clk();
                check({8'h00, cal_active}, 9'h001);
                repeat (n) cal_pulse(1'b1, 1'b0);
                cal_pulse(1'b1, 1'b1);
            end
        join
        check({dir_bit, offset}, {1'b0, n[7:0]});
        exp_q.push_back({1'b1, n[7:0]});
        u_host.read_byte(ADDR_OFFSET);
        // result register ignores host writes
        r = 8'($urandom);
        u_host.write_reg(ADDR_OFFSET, r);
        exp_q.push_back({1'b1, n[7:0]});
        u_host.read_byte(ADDR_OFFSET);
        repeat (4) step_clk();
        check({8'h00, exp_q.size() == 0}, 9'h001);
        results();
    end
endmodule // tb_single_wire_offset_link
